// [frame_cmd_pkg.sv]
/*
 Constants, codes and register map of the command-frame interpreter.
 Assumes one clock domain and frames on a byte stream.
*/
// Contract
// - Requests: header, destination, source, length, code, parameters, checksum.
// - Replies keep that order, destination is the master, source is us.
// - Length byte counts the code byte plus every parameter or data byte.
// - Accepted setting commands answer with code 0x7f and one data byte 0x00.
// - Step query 0xa4 takes step 1 to 10 and returns 28 bytes.
// - Step reply: index, mode, source, ramp, reserved, test, fall, limits, reserved.
// - Multi-byte values travel least significant byte first.
// - Preset set 0x25 carries exactly six bytes, stored then acknowledged.
// - Preset order: frequency 50/60, gain, withstand, insulation, restart, ground fault.
// - Preset query 0xa5 returns the six preset bytes in set order.
// - Store 0x26: slot 1 to 60, name 0 to 10 chars, saves steps and preset.
// - Recall 0x27: slot 1 to 60 becomes the working setup.
// - Delete 0x28: slot 1 to 60 erased, zero clears working steps and preset.
// - System set 0x29: contrast, buzzer, current cap mode, low-volt gain; acknowledged.
// - Contrast 1 to 15, buzzer volume 0 to 3.
// - Cap mode 1 limits AC current to 3 mA; gain byte 0 off, 1 on.
package frame_cmd_pkg;
	localparam logic [7:0] FRAME_HDR      = 8'hab;
	localparam logic [7:0] CMD_STEP_Q     = 8'ha4;
	localparam logic [7:0] CMD_PRESET_SET = 8'h25;
	localparam logic [7:0] CMD_PRESET_Q   = 8'ha5;
	localparam logic [7:0] CMD_STORE      = 8'h26;
	localparam logic [7:0] CMD_RECALL     = 8'h27;
	localparam logic [7:0] CMD_DELETE     = 8'h28;
	localparam logic [7:0] CMD_SYS_SET    = 8'h29;
	localparam logic [7:0] CMD_REPLY      = 8'h7f;
	localparam logic [7:0] REPLY_OK       = 8'h00;
	localparam logic [7:0] DEV_ADDR_RST   = 8'h01;
	localparam logic [7:0] CK_KEY_RST     = 8'h2b;
	localparam logic [7:0] FREQ_50        = 8'h32;
	localparam logic [7:0] FREQ_60        = 8'h3c;
	localparam logic [7:0] BOOL_MAX       = 8'h01;
	localparam logic [7:0] CONTRAST_MIN   = 8'h01;
	localparam logic [7:0] CONTRAST_MAX   = 8'h0f;
	localparam logic [7:0] BUZZER_MAX     = 8'h03;
	localparam logic [7:0] STEP_MAX       = 8'h0a;
	localparam logic [7:0] SLOT_MAX       = 8'h3c;
	localparam logic [7:0] LEN_STEP_Q     = 8'h02;
	localparam logic [7:0] LEN_PRESET_SET = 8'h07;
	localparam logic [7:0] LEN_NO_PARAM   = 8'h01;
	localparam logic [7:0] LEN_SLOT       = 8'h02;
	localparam logic [7:0] LEN_STORE_MAX  = 8'h0c;
	localparam logic [7:0] LEN_SYS_SET    = 8'h05;
	localparam logic [7:0] LEN_REPLY      = 8'h02;
	localparam logic [7:0] LEN_STEP_R     = 8'h1d;
	localparam logic [7:0] LEN_PRESET_R   = 8'h07;
	localparam int STEP_BYTES   = 28;
	localparam int STEP_COUNT   = 10;
	localparam int PRESET_BYTES = 6;
	localparam int SYS_BYTES    = 4;
	localparam int SLOT_COUNT   = 60;
	localparam int NAME_MAX     = 10;
	localparam int PARAM_MAX    = 11;
	localparam int PRESET_BASE  = STEP_BYTES * STEP_COUNT;
	localparam int IMAGE_BYTES  = PRESET_BASE + PRESET_BYTES;
	localparam int FRAME_OVERHEAD = 5;
	// System byte positions
	localparam int SYS_CONTRAST = 0;
	localparam int SYS_BUZZER   = 1;
	localparam int SYS_CAP      = 2;
	localparam int SYS_LVGAIN   = 3;
	localparam logic [7:0] SYS_CONTRAST_RST = 8'h08;
	// Register map, byte addresses
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_PRESET_LO = 8'h08;
	localparam logic [7:0] REG_PRESET_HI = 8'h0c;
	localparam logic [7:0] REG_SYSTEM    = 8'h10;
	localparam logic [7:0] REG_STEP_IDX  = 8'h14;
	localparam logic [7:0] REG_STEP_DATA = 8'h18;
	localparam int CTRL_CKEN_BIT = 8;
	localparam int CTRL_KEY_LSB  = 16;
	localparam int STAT_ACC_LSB  = 8;
	localparam int STAT_BAD_LSB  = 16;
endpackage

// [cmd_if.sv]
/*
 Carries a checked request frame from the receiver to the executor, plus receiver settings.
 Assumes both ends share clk; valid stands until take.
*/
`timescale 1ns/1ps
`default_nettype none
interface cmd_if;
	import frame_cmd_pkg::*;
	logic       valid;
	logic       take;
	logic       bad;
	logic [7:0] code;
	logic [7:0] src;
	logic [7:0] len;
	logic [7:0] param [PARAM_MAX];
	logic [7:0] own_addr;
	logic [7:0] ck_key;
	logic       ck_en;
	modport rx (output valid, bad, code, src, len, param, input take, own_addr, ck_key, ck_en);
	modport ex (input valid, bad, code, src, len, param, output take, own_addr, ck_key, ck_en);
endinterface
`default_nettype wire

// [frame_rx.sv]
/*
 Frame receiver: hunts for the header, checks address and checksum, holds one request.
 Assumes rx bytes come from logic on clk; holds off new bytes while a request waits.
*/
`timescale 1ns/1ps
`default_nettype none
module frame_rx import frame_cmd_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Byte stream in
	input  wire logic       rx_valid,
	input  wire logic [7:0] rx_data,
	output logic            rx_ready,
	// Request out
	cmd_if.rx               cv
);
	typedef enum {HUNT, DST, SRC, LEN, BODY, CKSUM, HOLD} rx_state_e;
	rx_state_e  state, next_state;
	logic [7:0] sum, next_sum;
	logic [7:0] idx, next_idx;
	logic       match, next_match;
	logic [7:0] code, next_code, src, next_src, len, next_len;
	logic [7:0] param [PARAM_MAX];
	logic [7:0] next_param [PARAM_MAX];
	logic       bad, next_bad;
	logic       beat;

	assign rx_ready = (state != HOLD);
	assign beat     = rx_valid && rx_ready;
	assign cv.valid = (state == HOLD);
	assign cv.bad   = bad;
	assign cv.code  = code;
	assign cv.src   = src;
	assign cv.len   = len;
	assign cv.param = param;

	always_comb begin
		next_state = state;
		next_sum   = sum;
		next_idx   = idx;
		next_match = match;
		next_code  = code;
		next_src   = src;
		next_len   = len;
		next_param = param;
		next_bad   = 1'b0;
		if (beat && state != HUNT && state != CKSUM)
			next_sum = 8'(sum + rx_data);
		case (state)
			HUNT: begin
				if (beat && rx_data == FRAME_HDR) begin
					next_sum   = FRAME_HDR;
					next_state = DST;
				end
			end
			DST: begin
				if (beat) begin
					next_match = (rx_data == cv.own_addr);
					next_state = SRC;
				end
			end
			SRC: begin
				if (beat) begin
					next_src   = rx_data;
					next_state = LEN;
				end
			end
			LEN: begin
				if (beat) begin
					next_len   = rx_data;
					next_idx   = 8'h00;
					next_state = (rx_data == 8'h00) ? CKSUM : BODY;
				end
			end
			BODY: begin
				if (beat) begin
					if (idx == 8'h00)
						next_code = rx_data;
					else if (int'(idx) <= PARAM_MAX)
						next_param[int'(idx) - 1] = rx_data;
					next_idx = 8'(idx + 8'h01);
					if (next_idx == len)
						next_state = CKSUM;
				end
			end
			CKSUM: begin
				if (beat) begin
					// Overlong frames are swallowed whole so the next header is found cleanly
					if (match && len != 8'h00 && int'(len) <= PARAM_MAX + 1 &&
					    (!cv.ck_en || rx_data == (sum ^ cv.ck_key))) begin
						next_state = HOLD;
					end else begin
						next_bad   = 1'b1;
						next_state = HUNT;
					end
				end
			end
			HOLD: begin
				if (cv.take)
					next_state = HUNT;
			end
			default: next_state = HUNT;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= HUNT;
			sum   <= 8'h00;
			idx   <= 8'h00;
			match <= 1'b0;
			code  <= 8'h00;
			src   <= 8'h00;
			len   <= 8'h00;
			bad   <= 1'b0;
			for (int i = 0; i < PARAM_MAX; i++)
				param[i] <= 8'h00;
		end else begin
			state <= next_state;
			sum   <= next_sum;
			idx   <= next_idx;
			match <= next_match;
			code  <= next_code;
			src   <= next_src;
			len   <= next_len;
			bad   <= next_bad;
			param <= next_param;
		end
	end
endmodule
`default_nettype wire

// [frame_cmd.sv]
/*
 Command-frame interpreter top: runs checked requests, keeps working setup and
 60 saved slots, sends replies, offers an AHB-Lite slave.
 Assumes byte streams on clk and a single AHB-Lite master.
*/
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module frame_cmd import frame_cmd_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Byte stream in
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             rx_ready,
	// Byte stream out
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	// Settings out
	output logic             ac_current_cap_3ma,
	output logic             low_volt_gain_control,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	typedef enum {IDLE, COPY, SEND} ex_state_e;
	typedef enum {CP_STORE, CP_RECALL, CP_CLEAR} copy_e;

	cmd_if cv ();

	frame_rx u_rx (
		.clk      (clk),
		.rst      (rst),
		.rx_valid (rx_valid),
		.rx_data  (rx_data),
		.rx_ready (rx_ready),
		.cv       (cv)
	);

	// Working image: ten steps then the preset bytes
	logic [7:0]  work_mem [IMAGE_BYTES];
	logic [7:0]  slot_mem [SLOT_COUNT * IMAGE_BYTES];
	logic [7:0]  name_mem [SLOT_COUNT * NAME_MAX];

	ex_state_e   state, next_state;
	copy_e       dir, next_dir;
	logic [8:0]  cnt, next_cnt;
	logic [5:0]  slot, next_slot;
	logic [7:0]  peer, next_peer;
	logic [7:0]  rcode, next_rcode;
	logic [7:0]  rlen, next_rlen;
	logic [8:0]  dbase, next_dbase;
	logic [7:0]  tx_idx, next_tx_idx;
	logic [7:0]  tx_sum, next_tx_sum;
	logic        next_tx_valid;
	logic [7:0]  next_tx_data;
	logic [59:0] slot_used, next_slot_used;
	logic [7:0]  sys [SYS_BYTES];
	logic [7:0]  next_sys [SYS_BYTES];
	logic [7:0]  acc_cnt, next_acc_cnt, bad_cnt, next_bad_cnt;
	logic [7:0]  own_addr, next_own_addr, ck_key, next_ck_key;
	logic        ck_en, next_ck_en;
	logic [8:0]  step_idx, next_step_idx;
	logic        wr_pend, next_wr_pend;
	logic [7:0]  wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic        ahb_req, ok, preset_we, name_we, mem_we;
	logic [8:0]  mem_addr;
	logic [7:0]  mem_data;
	logic [14:0] slot_base;

	assign cv.own_addr = own_addr;
	assign cv.ck_key   = ck_key;
	assign cv.ck_en    = ck_en;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign ahb_req     = hsel && htrans[1] && hready;
	assign slot_base   = 15'(int'(slot) * IMAGE_BYTES);

	function automatic logic is_bool(input logic [7:0] v);
		return v <= BOOL_MAX;
	endfunction

	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		return (v >= lo) && (v <= hi);
	endfunction

	// Parameter checks per command; anything failing is silently dropped
	function automatic logic req_ok(input logic [7:0] c, input logic [7:0] l, input logic [7:0] p [PARAM_MAX]);
		logic r;
		r = 1'b0;
		case (c)
			CMD_STEP_Q:     r = (l == LEN_STEP_Q) && in_range(p[0], 8'h01, STEP_MAX);
			CMD_PRESET_SET: r = (l == LEN_PRESET_SET) && (p[0] == FREQ_50 || p[0] == FREQ_60) &&
			                    is_bool(p[1]) && is_bool(p[2]) && is_bool(p[3]) &&
			                    is_bool(p[4]) && is_bool(p[5]);
			CMD_PRESET_Q:   r = (l == LEN_NO_PARAM);
			CMD_STORE:      r = in_range(l, LEN_SLOT, LEN_STORE_MAX) && in_range(p[0], 8'h01, SLOT_MAX);
			CMD_RECALL:     r = (l == LEN_SLOT) && in_range(p[0], 8'h01, SLOT_MAX);
			CMD_DELETE:     r = (l == LEN_SLOT) && (p[0] <= SLOT_MAX);
			CMD_SYS_SET:    r = (l == LEN_SYS_SET) && in_range(p[0], CONTRAST_MIN, CONTRAST_MAX) &&
			                    (p[1] <= BUZZER_MAX) && is_bool(p[2]) && is_bool(p[3]);
			default:        r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == REG_CTRL)
			d = {8'h00, ck_key, 7'h00, ck_en, own_addr};
		else if (a == REG_STATUS)
			d = {8'h00, bad_cnt, acc_cnt, 7'h00, state != IDLE};
		else if (a == REG_PRESET_LO)
			d = {work_mem[PRESET_BASE + 3], work_mem[PRESET_BASE + 2],
			     work_mem[PRESET_BASE + 1], work_mem[PRESET_BASE]};
		else if (a == REG_PRESET_HI)
			d = {16'h0000, work_mem[PRESET_BASE + 5], work_mem[PRESET_BASE + 4]};
		else if (a == REG_SYSTEM)
			d = {sys[SYS_LVGAIN], sys[SYS_CAP], sys[SYS_BUZZER], sys[SYS_CONTRAST]};
		else if (a == REG_STEP_IDX)
			d = {23'h000000, step_idx};
		else if (a == REG_STEP_DATA)
			d = (int'(step_idx) < IMAGE_BYTES) ? {24'h000000, work_mem[step_idx]} : 32'h0000_0000;
		return d;
	endfunction

	// Byte k of the reply frame
	function automatic logic [7:0] tx_byte(input logic [7:0] k);
		logic [7:0] b;
		b = 8'h00;
		if (k == 8'h00)
			b = FRAME_HDR;
		else if (k == 8'h01)
			b = peer;
		else if (k == 8'h02)
			b = own_addr;
		else if (k == 8'h03)
			b = rlen;
		else if (k == 8'h04)
			b = rcode;
		else if (k == 8'(rlen + 8'h04))
			b = tx_sum ^ ck_key;
		else if (rcode == CMD_REPLY)
			b = REPLY_OK;
		else
			b = work_mem[9'(int'(dbase) + int'(k) - FRAME_OVERHEAD)];
		return b;
	endfunction

	always_comb begin
		next_state     = state;
		next_dir       = dir;
		next_cnt       = cnt;
		next_slot      = slot;
		next_peer      = peer;
		next_rcode     = rcode;
		next_rlen      = rlen;
		next_dbase     = dbase;
		next_tx_idx    = tx_idx;
		next_tx_sum    = tx_sum;
		next_tx_valid  = tx_valid;
		next_tx_data   = tx_data;
		next_slot_used = slot_used;
		next_sys       = sys;
		next_acc_cnt   = acc_cnt;
		next_bad_cnt   = 8'(bad_cnt + {7'h00, cv.bad});
		next_own_addr  = own_addr;
		next_ck_key    = ck_key;
		next_ck_en     = ck_en;
		next_step_idx  = step_idx;
		next_wr_pend   = ahb_req && hwrite;
		next_wr_addr   = ahb_req ? haddr[7:0] : wr_addr;
		next_hrdata    = (ahb_req && !hwrite) ? reg_read(haddr[7:0]) : hrdata;
		ok             = req_ok(cv.code, cv.len, cv.param);
		cv.take        = 1'b0;
		preset_we      = 1'b0;
		name_we        = 1'b0;
		mem_we         = 1'b0;
		mem_addr       = step_idx;
		mem_data       = hwdata[7:0];
		if (wr_pend) begin
			if (wr_addr == REG_CTRL) begin
				next_own_addr = hwdata[7:0];
				next_ck_en    = hwdata[CTRL_CKEN_BIT];
				next_ck_key   = hwdata[CTRL_KEY_LSB +: 8];
			end else if (wr_addr == REG_STEP_IDX) begin
				next_step_idx = hwdata[8:0];
			end else if (wr_addr == REG_STEP_DATA) begin
				// Dropped while a command runs so software never races the copy engine
				mem_we        = (state == IDLE) && (int'(step_idx) < IMAGE_BYTES);
				next_step_idx = 9'(step_idx + 9'h001);
			end
		end
		case (state)
			IDLE: begin
				if (cv.valid && !mem_we) begin
					cv.take      = 1'b1;
					next_peer    = cv.src;
					next_rcode   = CMD_REPLY;
					next_rlen    = LEN_REPLY;
					next_slot    = 6'(cv.param[0] - 8'h01);
					next_cnt     = 9'h000;
					next_tx_idx  = 8'h00;
					next_tx_sum  = 8'h00;
					next_state   = SEND;
					if (!ok || (cv.code == CMD_RECALL && !slot_used[6'(cv.param[0] - 8'h01)])) begin
						next_bad_cnt = 8'(bad_cnt + 8'h01);
						next_state   = IDLE;
					end else begin
						next_acc_cnt = 8'(acc_cnt + 8'h01);
						case (cv.code)
							CMD_STEP_Q: begin
								next_rcode = CMD_STEP_Q;
								next_rlen  = LEN_STEP_R;
								next_dbase = 9'((int'(cv.param[0]) - 1) * STEP_BYTES);
							end
							CMD_PRESET_Q: begin
								next_rcode = CMD_PRESET_Q;
								next_rlen  = LEN_PRESET_R;
								next_dbase = 9'(PRESET_BASE);
							end
							CMD_PRESET_SET: preset_we = 1'b1;
							CMD_STORE: begin
								name_we                                 = 1'b1;
								next_slot_used[6'(cv.param[0] - 8'h01)] = 1'b1;
								next_dir                                = CP_STORE;
								next_state                              = COPY;
							end
							CMD_RECALL: begin
								next_dir   = CP_RECALL;
								next_state = COPY;
							end
							CMD_DELETE: begin
								if (cv.param[0] == 8'h00) begin
									next_dir   = CP_CLEAR;
									next_state = COPY;
								end else begin
									next_slot_used[6'(cv.param[0] - 8'h01)] = 1'b0;
								end
							end
							CMD_SYS_SET: begin
								for (int i = 0; i < SYS_BYTES; i++)
									next_sys[i] = cv.param[i];
							end
							default: next_state = IDLE;
						endcase
					end
				end
			end
			COPY: begin
				// One byte per clock; a full image move costs 286 cycles
				mem_addr = cnt;
				mem_data = (dir == CP_RECALL) ? slot_mem[15'(int'(slot_base) + int'(cnt))] : 8'h00;
				mem_we   = (dir != CP_STORE);
				next_cnt = 9'(cnt + 9'h001);
				if (int'(cnt) == IMAGE_BYTES - 1)
					next_state = SEND;
			end
			SEND: begin
				if (!tx_valid || tx_ready) begin
					if (tx_idx == 8'(rlen + FRAME_OVERHEAD)) begin
						next_tx_valid = 1'b0;
						next_state    = IDLE;
					end else begin
						next_tx_valid = 1'b1;
						next_tx_data  = tx_byte(tx_idx);
						next_tx_sum   = 8'(tx_sum + tx_byte(tx_idx));
						next_tx_idx   = 8'(tx_idx + 8'h01);
					end
				end
			end
			default: next_state = IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state                 <= IDLE;
			dir                   <= CP_STORE;
			cnt                   <= 9'h000;
			slot                  <= 6'h00;
			peer                  <= 8'h00;
			rcode                 <= CMD_REPLY;
			rlen                  <= LEN_REPLY;
			dbase                 <= 9'h000;
			tx_idx                <= 8'h00;
			tx_sum                <= 8'h00;
			tx_valid              <= 1'b0;
			tx_data               <= 8'h00;
			slot_used             <= '0;
			acc_cnt               <= 8'h00;
			bad_cnt               <= 8'h00;
			own_addr              <= DEV_ADDR_RST;
			ck_key                <= CK_KEY_RST;
			ck_en                 <= 1'b1;
			step_idx              <= 9'h000;
			wr_pend               <= 1'b0;
			wr_addr               <= 8'h00;
			hrdata                <= 32'h0000_0000;
			ac_current_cap_3ma    <= 1'b0;
			low_volt_gain_control <= 1'b0;
			for (int i = 0; i < SYS_BYTES; i++)
				sys[i] <= (i == SYS_CONTRAST) ? SYS_CONTRAST_RST : 8'h00;
		end else begin
			state                 <= next_state;
			dir                   <= next_dir;
			cnt                   <= next_cnt;
			slot                  <= next_slot;
			peer                  <= next_peer;
			rcode                 <= next_rcode;
			rlen                  <= next_rlen;
			dbase                 <= next_dbase;
			tx_idx                <= next_tx_idx;
			tx_sum                <= next_tx_sum;
			tx_valid              <= next_tx_valid;
			tx_data               <= next_tx_data;
			slot_used             <= next_slot_used;
			sys                   <= next_sys;
			acc_cnt               <= next_acc_cnt;
			bad_cnt               <= next_bad_cnt;
			own_addr              <= next_own_addr;
			ck_key                <= next_ck_key;
			ck_en                 <= next_ck_en;
			step_idx              <= next_step_idx;
			wr_pend               <= next_wr_pend;
			wr_addr               <= next_wr_addr;
			hrdata                <= next_hrdata;
			ac_current_cap_3ma    <= (next_sys[SYS_CAP] == BOOL_MAX);
			low_volt_gain_control <= (next_sys[SYS_LVGAIN] == BOOL_MAX);
		end
	end

	// Storage arrays carry no reset; only delete 0 clears the working image
	always_ff @(posedge clk) begin
		if (mem_we)
			work_mem[mem_addr] <= mem_data;
		if (preset_we) begin
			for (int i = 0; i < PRESET_BYTES; i++)
				work_mem[PRESET_BASE + i] <= cv.param[i];
		end
		if (state == COPY && dir == CP_STORE)
			slot_mem[15'(int'(slot_base) + int'(cnt))] <= work_mem[cnt];
		if (name_we) begin
			for (int i = 0; i < NAME_MAX; i++)
				name_mem[int'(next_slot) * NAME_MAX + i] <= (i + 2 <= int'(cv.len)) ? cv.param[i + 1] : 8'h00;
		end
	end
endmodule
`default_nettype wire

// [frame_cmd_chk.sv]
/* Checker for reply framing and bus response of the command-frame interpreter.
 Assumes the master sits at 0x70 and the device keeps its reset address. */
`timescale 1ns/1ps
`default_nettype none
module frame_cmd_chk import frame_cmd_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Reply stream
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_ready,
	// Bus response
	input  wire logic       hreadyout,
	input  wire logic       hresp
);
	logic [5:0] idx;
	logic [5:0] next_idx;
	logic [7:0] len;
	logic [7:0] code;
	logic       hs;
	logic       last;
	assign hs = tx_valid && tx_ready;
	// Length is only trusted once it has gone by
	assign last = idx > 6'h04 && {2'b00, idx} == len + 8'h04;
	always_comb begin
		next_idx = idx;
		if (hs)
			next_idx = last ? 6'h00 : idx + 6'h01;
	end
	always_ff @(posedge clk) begin
		idx <= rst ? 6'h00 : next_idx;
		if (hs && idx == 6'h03)
			len <= tx_data;
		if (hs && idx == 6'h04)
			code <= tx_data;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_tx_hold: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)) else $error("reply byte dropped while stalled");
	a_hdr_first: assert property (
		hs && idx == 6'h00 |-> tx_data == FRAME_HDR) else $error("reply header wrong");
	a_dst_peer: assert property (
		hs && idx == 6'h01 |-> tx_data == 8'h70) else $error("reply destination wrong");
	a_src_own: assert property (
		hs && idx == 6'h02 |-> tx_data == DEV_ADDR_RST) else $error("reply source wrong");
	a_len_code: assert property (
		hs && idx == 6'h04 |-> (len == LEN_REPLY && tx_data == CMD_REPLY) || (len == LEN_STEP_R &&
		tx_data == CMD_STEP_Q) || (len == LEN_PRESET_R && tx_data == CMD_PRESET_Q)) else $error("length and code disagree");
	a_ack_zero: assert property (
		hs && idx == 6'h05 && code == CMD_REPLY |-> tx_data == REPLY_OK) else $error("reply data not zero");
	a_step_first: assert property (
		hs && idx == 6'h05 && code == CMD_STEP_Q |-> tx_data inside {[8'h01:STEP_MAX]}) else $error("step index bad");
	a_frame_end: assert property (
		hs && last |=> !tx_valid) else $error("bytes after checksum");
	a_bus_okay: assert property (
		hreadyout && !hresp) else $error("bus response not okay");
	c_ack: cover property (hs && idx == 6'h04 && tx_data == CMD_REPLY);
	c_step: cover property (hs && idx == 6'h04 && tx_data == CMD_STEP_Q);
	c_stall: cover property (tx_valid && !tx_ready);
endmodule
bind frame_cmd frame_cmd_chk chk_u (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// [remote_master.sv]
/* Remote master model: sends request frames and collects reply bytes.
 Assumes the device clock; slow makes the sink ready only on every other cycle. */
`timescale 1ns/1ps
`default_nettype none
module remote_master import frame_cmd_pkg::*; (
	// Clock
	input  wire logic       clk,
	// Request stream
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       rx_ready,
	// Reply stream
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	// Sink pacing
	input  wire logic       slow
);
	logic [7:0] got [$];
	logic       ph = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b1;
	end
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		ph       <= ~ph;
		tx_ready <= !slow || ph;
	end
	function automatic logic [7:0] cks(input logic [7:0] f [$]);
		logic [7:0] s;
		s = 8'h00;
		foreach (f[i])
			s = s + f[i];
		return s ^ CK_KEY_RST;
	endfunction
	// Parameters arrive already least significant byte first
	task automatic send(input logic [7:0] dst, input logic [7:0] b [$]);
		logic [7:0] f [$];
		f = {FRAME_HDR, dst, 8'h70, 8'(b.size())};
		f = {f, b};
		f.push_back(cks(f));
		foreach (f[i]) begin
			rx_valid <= 1'b1;
			rx_data  <= f[i];
			do @(posedge clk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		// Released line shows the inverse so a stale byte cannot pass
		rx_data  <= ~f[f.size() - 1];
	endtask
endmodule
`default_nettype wire

// [test_test_setup_command_frames.sv]
/* Bench: request frames through the master model, registers over AHB-Lite.
 Assumes one clock; expected replies are built from the rules. */
`timescale 1ns/1ps
`default_nettype none
module test_test_setup_command_frames import frame_cmd_pkg::*;;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rx_valid, rx_ready, tx_valid, tx_ready, cap, gain, slow;
	logic        hsel, hwrite, hreadyout, hresp;
	logic [7:0]  rx_data, tx_data;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [7:0]  ok [$], none [$], st [$], pr [$];
	int          n_fail = 0, n_checks = 0;
	localparam logic [7:0] ME = DEV_ADDR_RST;
	always #4 clk = ~clk;
	frame_cmd dut_u (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .ac_current_cap_3ma(cap),
		.low_volt_gain_control(gain), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	remote_master m_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr  <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// An empty expected reply means the frame must be dropped
	task automatic txn(input logic [7:0] dst, input logic [7:0] rq [$], input logic [7:0] rs [$]);
		logic [7:0] e [$];
		m_u.send(dst, rq);
		e = {FRAME_HDR, 8'h70, ME, 8'(rs.size())};
		e = {e, rs};
		e.push_back(m_u.cks(e));
		repeat (rs.size() ? 1200 : 40)
			if (m_u.got.size() < e.size())
				@(posedge clk);
		chk(m_u.got.size(), rs.size() ? e.size() : 0);
		foreach (m_u.got[i])
			if (i < e.size())
				chk(m_u.got[i], e[i]);
		m_u.got.delete();
	endtask
	initial begin
		{hsel, hwrite, slow} = 3'b000;
		htrans = 2'b00;
		hsize = 3'b010;
		haddr = 32'h0;
		hwdata = 32'h0;
		ok = {CMD_REPLY, REPLY_OK};
		pr = {FREQ_50, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, REG_CTRL, 32'h0);
		chk(r, 32'h002b0101);
		ahb(1'b0, 8'h40, 32'h0);
		chk(r, 32'h0);
		txn(ME, {CMD_DELETE, 8'h00}, ok);
		txn(ME, {CMD_PRESET_Q}, {CMD_PRESET_Q, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
		slow <= 1'b1;
		txn(ME, {CMD_PRESET_SET, pr}, ok);
		txn(ME, {CMD_PRESET_Q}, {CMD_PRESET_Q, pr});
		slow <= 1'b0;
		ahb(1'b0, REG_PRESET_LO, 32'h0);
		chk(r, 32'h00010032);
		txn(ME, {CMD_PRESET_SET, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, none);
		txn(ME, {CMD_PRESET_SET, FREQ_60, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00}, none);
		txn(ME, {CMD_SYS_SET, 8'h0a, 8'h03, 8'h01, 8'h01}, ok);
		chk({cap, gain}, 32'h3);
		txn(ME, {CMD_SYS_SET, 8'h00, 8'h00, 8'h00, 8'h00}, none);
		for (int b = 0; b < 4; b++) begin
			txn(ME, {CMD_SYS_SET, 8'h0f, 8'(b), 8'h00, 8'h00}, ok);
			ahb(1'b0, REG_SYSTEM, 32'h0);
			chk(r, {16'h0, 8'(b), 8'h0f});
		end
		chk({cap, gain}, 32'h0);
		ahb(1'b1, REG_STEP_IDX, 32'h1c);
		st = {CMD_STEP_Q};
		for (int i = 0; i < STEP_BYTES; i++) begin
			ahb(1'b1, REG_STEP_DATA, 32'(3 * i + 2));
			st.push_back(8'(3 * i + 2));
		end
		txn(ME, {CMD_STEP_Q, 8'h02}, st);
		txn(ME, {CMD_STEP_Q, 8'h0b}, none);
		txn(ME, {CMD_STORE, 8'h3c, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a}, ok);
		txn(ME, {CMD_STORE, 8'h3d}, none);
		txn(ME, {CMD_DELETE, 8'h00}, ok);
		txn(ME, {CMD_RECALL, 8'h3c}, ok);
		txn(ME, {CMD_STEP_Q, 8'h02}, st);
		txn(ME, {CMD_PRESET_Q}, {CMD_PRESET_Q, pr});
		txn(ME, {CMD_RECALL, 8'h05}, none);
		txn(ME, {CMD_DELETE, 8'h3c}, ok);
		txn(ME, {CMD_RECALL, 8'h3c}, none);
		txn(8'h02, {CMD_PRESET_Q}, none);
		ahb(1'b1, REG_CTRL, 32'h101);
		txn(ME, {CMD_PRESET_Q}, none);
		report_and_stop();
	end
	initial begin
		repeat (50000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
